/* sswd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the two-wire bus: a start, one byte, then a stop
module sswd_host_model (
   input wire logic go,
   input wire logic hold_low,
   output logic scl,
   output logic sda
);
   logic sda_r;
   int i;
   // both lines idle high on their pull-ups; scl stands still between frames
   initial begin
      scl = 1'h1;
      sda_r = 1'h1;
   end
   // a hung host can clamp the data line low
   assign sda = hold_low ? 1'h0 : sda_r;
   // data moves only while scl is low, so the one fall at scl high is the start
   always @(posedge go) begin
      sda_r = 1'h0;
      #80 scl = 1'h0;
      for (i = 0; i < 8; i++) begin
         #40 sda_r = 1'($urandom_range(0, 1));
         #40 scl = 1'h1;
         #80 scl = 1'h0;
      end
      #40 sda_r = 1'h0;
      #40 scl = 1'h1;
      #80 sda_r = 1'h1;
   end
endmodule
`default_nettype wire

/* sswd_pkg.sv */
// Function
// - a data fall while the clock line is high restarts the watchdog count
// - no start before the selected interval ends drives the reset output active
// - watchdog reset happens only when enabled; disabled, the data line never resets
// - host picks one of three intervals; the choice survives supply cycling
// - reset output is active whenever the supply-low indication is active
// - after supply-low clears, reset stays active until supply is good 250ms
// - reset is active at power-up, released after supply good 200ms (parameter)
// - reset output is open-drain, with build-time active level low or high
// - during power-up reset, bus transactions addressed to the device are refused
// - write-protect pin high with protect enable set blocks control writes
// - period code 00 1.4s, 01 600ms, 10 200ms, 11 disabled (default)
// - reset from low supply or timeout aborts bus traffic; running writes finish
package sswd_pkg;
   // time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_DELAY_MS = 200;
   localparam int LOW_DELAY_MS = 250;
   localparam int WD_LONG_MS = 1400;
   localparam int WD_MID_MS = 600;
   localparam int WD_SHORT_MS = 200;
   localparam int MS_W = 11;
   localparam int DIV_W = 16;

   // register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] WD_COUNT_OFS = 8'h10;

   // control field positions and reset values
   localparam int PROT_EN_POS = 7;
   localparam int PSEL_HI_POS = 6;
   localparam int PSEL_LO_POS = 5;
   localparam logic [1:0] PSEL_RESET = 2'h3;
   localparam logic [1:0] PSEL_OFF = 2'h3;
   localparam logic PROT_EN_RESET = 1'b0;

   // status bits
   localparam int ST_RESET_POS = 0;
   localparam int ST_LOW_POS = 1;
   localparam int ST_WP_POS = 2;
   localparam int ST_WDEN_POS = 3;
   localparam int ST_POR_POS = 4;

   // event bits
   localparam int EV_W = 3;
   localparam int EV_WD = 0;
   localparam int EV_LOW = 1;
   localparam int EV_BLOCK = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_POR, ST_LOW, ST_DELAY, ST_RUN} sswd_state_t;

   // interval in ms for a period code, zero when disabled
   function automatic logic [MS_W-1:0] sswd_wd_limit(input logic [1:0] psel);
      logic [MS_W-1:0] lim;
      lim = '0;
      unique case (psel)
         2'h0: lim = MS_W'(WD_LONG_MS);
         2'h1: lim = MS_W'(WD_MID_MS);
         2'h2: lim = MS_W'(WD_SHORT_MS);
         2'h3: lim = '0;
      endcase
      return lim;
   endfunction

   // true for a mapped register address
   function automatic logic sswd_addr_ok(input logic [ADDR_W-1:0] a);
      return (a == CTRL_OFS) || (a == STATUS_OFS) || (a == IRQ_STAT_OFS) ||
             (a == IRQ_MASK_OFS) || (a == WD_COUNT_OFS);
   endfunction
endpackage

/* sswd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output follows once stages two and three agree
module sswd_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   // s1 feeds s2 only, to keep metastability out of the agreement check
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // filtered level, idle high like the bus lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= 1'b1;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule
`default_nettype wire

/* sswd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sswd_top
   import sswd_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int POR_MS = POR_DELAY_MS,
   parameter int LOW_MS = LOW_DELAY_MS,
   parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   input wire logic supply_low_in,
   input wire logic nv_write_busy,
   output logic sys_reset_o,
   output logic sys_reset_oe,
   output logic bus_enable,
   output logic comm_abort,
   output logic nv_write_permit,
   output logic irq,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
   localparam logic [MS_W-1:0] POR_LAST = MS_W'(POR_MS - 1);
   localparam logic [MS_W-1:0] LOW_LAST = MS_W'(LOW_MS - 1);

   logic scl_f;
   logic sda_f;
   logic wp_f;
   logic low_f;
   logic sda_prev;
   logic start_det;
   logic [DIV_W-1:0] div_cnt;
   logic ms_tick;
   sswd_state_t state;
   sswd_state_t next_state;
   logic [MS_W-1:0] dly_cnt;
   logic [MS_W-1:0] wd_cnt;
   logic [MS_W-1:0] wd_lim;
   logic wd_en;
   logic wd_fire;
   logic reset_active;
   logic [1:0] psel;
   logic prot_en;
   logic [EV_W-1:0] irq_stat;
   logic [EV_W-1:0] irq_mask;
   logic [EV_W-1:0] ev_set;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic ctrl_wr;
   logic ctrl_blocked;
   logic low_prev;

   // pins from outside the clock domain, scl among them as a sampled level
   logic [3:0] pin_raw;
   logic [3:0] pin_f;
   assign pin_raw = {supply_low_in, wp_in, sda_in, scl_in};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         sswd_sync u_sync (
            .clk(clk),
            .rst(rst),
            .pin(pin_raw[gi]),
            .level(pin_f[gi])
         );
      end
   endgenerate
   assign scl_f = pin_f[0];
   assign sda_f = pin_f[1];
   assign wp_f = pin_f[2];
   assign low_f = pin_f[3];

   // 1 ms enable pulse; all supervisor timing counts these
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign ms_tick = (div_cnt == DIV_LAST);

   // start condition: data falls while clock line is high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_prev <= 1'b1;
      end else begin
         sda_prev <= sda_f;
      end
   end
   assign start_det = sda_prev && !sda_f && scl_f;

   // reset sequencer: power-up hold, low supply, release delay, running
   always_comb begin
      next_state = state;
      unique case (state)
         ST_POR: begin
            if (!low_f && ms_tick && dly_cnt == POR_LAST) begin
               next_state = ST_RUN;
            end
         end
         ST_LOW: begin
            if (!low_f) begin
               next_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (low_f) begin
               next_state = ST_LOW;
            end else if (ms_tick && dly_cnt == LOW_LAST) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (low_f) begin
               next_state = ST_LOW;
            end else if (wd_fire) begin
               next_state = ST_DELAY;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_POR;
      end else begin
         state <= next_state;
      end
   end

   // release delay counter, cleared on any state change or low supply
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dly_cnt <= '0;
      end else if (next_state != state || low_f) begin
         dly_cnt <= '0;
      end else if (ms_tick) begin
         dly_cnt <= dly_cnt + 1'b1;
      end
   end

   // reset level and abort pulse, registered so the pin never glitches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_active <= 1'b1;
         comm_abort <= 1'b0;
      end else begin
         reset_active <= (next_state != ST_RUN);
         comm_abort <= (state == ST_RUN) && (next_state != ST_RUN);
      end
   end

   // open drain: only ever pulls low, enable follows the variant's polarity
   assign sys_reset_o = 1'b0;
   assign sys_reset_oe = RESET_ACTIVE_HIGH ? !reset_active : reset_active;
   assign bus_enable = !reset_active;
   assign nv_write_permit = !reset_active || nv_write_busy;

   // watchdog: held at zero outside run so each release gives a full interval
   assign wd_lim = sswd_wd_limit(psel);
   assign wd_en = (psel != PSEL_OFF);
   assign wd_fire = (state == ST_RUN) && wd_en && ms_tick && (wd_cnt == wd_lim - 1'b1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_cnt <= '0;
      end else if (state != ST_RUN || start_det || !wd_en) begin
         wd_cnt <= '0;
      end else if (ms_tick) begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end

   // write channels taken independently, committed once both are held
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= sswd_addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control byte; these bits stand in for nonvolatile cells, so only the
   // chip-level rst clears them and supply cycling leaves them untouched
   assign ctrl_wr = do_write && (aw_addr_q == CTRL_OFS) && w_strb_q[0];
   assign ctrl_blocked = wp_f && prot_en;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psel <= PSEL_RESET;
         prot_en <= PROT_EN_RESET;
      end else if (ctrl_wr && !ctrl_blocked) begin
         psel <= {w_data_q[PSEL_HI_POS], w_data_q[PSEL_LO_POS]};
         prot_en <= w_data_q[PROT_EN_POS];
      end
   end

   // events; a set in the same cycle as a one-write wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_prev <= 1'b1; // filtered level idles high after rst, so no false rise
      end else begin
         low_prev <= low_f;
      end
   end
   always_comb begin
      ev_set = '0;
      ev_set[EV_WD] = wd_fire;
      ev_set[EV_LOW] = low_f && !low_prev;
      ev_set[EV_BLOCK] = ctrl_wr && ctrl_blocked;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat <= '0;
      end else if (do_write && aw_addr_q == IRQ_STAT_OFS && w_strb_q[0]) begin
         irq_stat <= (irq_stat & ~w_data_q[EV_W-1:0]) | ev_set;
      end else begin
         irq_stat <= irq_stat | ev_set;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask <= '0;
      end else if (do_write && aw_addr_q == IRQ_MASK_OFS && w_strb_q[0]) begin
         irq_mask <= w_data_q[EV_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // read channel: one-cycle answer, data registered
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= sswd_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata <= '0;
         unique case (s_axi_araddr)
            CTRL_OFS: begin
               s_axi_rdata[PROT_EN_POS] <= prot_en;
               s_axi_rdata[PSEL_HI_POS] <= psel[1];
               s_axi_rdata[PSEL_LO_POS] <= psel[0];
            end
            STATUS_OFS: begin
               s_axi_rdata[ST_RESET_POS] <= reset_active;
               s_axi_rdata[ST_LOW_POS] <= low_f;
               s_axi_rdata[ST_WP_POS] <= wp_f;
               s_axi_rdata[ST_WDEN_POS] <= wd_en;
               s_axi_rdata[ST_POR_POS] <= (state == ST_POR);
            end
            IRQ_STAT_OFS: s_axi_rdata[EV_W-1:0] <= irq_stat;
            IRQ_MASK_OFS: s_axi_rdata[EV_W-1:0] <= irq_mask;
            WD_COUNT_OFS: s_axi_rdata[MS_W-1:0] <= wd_cnt;
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   a_start_restarts: assert property (@(posedge clk) disable iff (rst)
      start_det |=> wd_cnt == '0)
      else $error("start condition did not restart watchdog");
   a_wd_reset: assert property (@(posedge clk) disable iff (rst)
      wd_fire && !low_f |=> reset_active && state == ST_DELAY)
      else $error("watchdog expiry did not assert reset");
   a_wd_off_quiet: assert property (@(posedge clk) disable iff (rst)
      (psel == PSEL_OFF) && state == ST_RUN && !low_f |=> !reset_active)
      else $error("watchdog fired while disabled");
   a_nv_kept: assert property (@(posedge clk) disable iff (rst)
      !ctrl_wr |=> $stable(psel) && $stable(prot_en))
      else $error("period select changed without a write");
   a_low_resets: assert property (@(posedge clk) disable iff (rst)
      low_f |=> reset_active ##1 reset_active)
      else $error("low supply did not hold reset");
   a_release_timed: assert property (@(posedge clk) disable iff (rst)
      $fell(reset_active) |-> $past(dly_cnt) == LOW_LAST || $past(dly_cnt) == POR_LAST)
      else $error("reset released before its delay");
   a_por_hold: assert property (@(posedge clk) disable iff (rst)
      state == ST_POR |-> reset_active)
      else $error("reset not active in power-up phase");
   a_pin_level: assert property (@(posedge clk) disable iff (rst)
      sys_reset_oe == (reset_active ^ RESET_ACTIVE_HIGH) && !sys_reset_o)
      else $error("reset pin enable disagrees with polarity");
   a_bus_refused: assert property (@(posedge clk) disable iff (rst)
      reset_active |-> !bus_enable)
      else $error("bus enabled during reset");
   a_wp_blocks: assert property (@(posedge clk) disable iff (rst)
      ctrl_wr && ctrl_blocked |=> $stable(psel) && irq_stat[EV_BLOCK])
      else $error("protected control write took effect");
   a_period_code: assert property (@(posedge clk) disable iff (rst)
      psel == 2'h2 |-> wd_lim == MS_W'(WD_SHORT_MS))
      else $error("period code decodes wrongly");
   a_abort_pulse: assert property (@(posedge clk) disable iff (rst)
      $rose(reset_active) |-> comm_abort ##1 !comm_abort)
      else $error("reset entry without abort pulse");
   a_delay_restart: assert property (@(posedge clk) disable iff (rst)
      state == ST_DELAY && low_f |=> dly_cnt == '0 && state == ST_LOW)
      else $error("release delay not restarted");
   a_release_full: assert property (@(posedge clk) disable iff (rst)
      $fell(reset_active) |-> wd_cnt == '0)
      else $error("watchdog not restarted at release");
endmodule
`default_nettype wire

/* supply_supervisor_watchdog_reset_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_reset_tb;
   import sswd_pkg::*;
   localparam int TK = 10;
   localparam int PM = 4;
   localparam int LM = 5;
   logic clk = 1'h0, rst = 1'h1, wp = 1'h0, low = 1'h0, nvb = 1'h0;
   logic go = 1'h0, hold = 1'h0, scl, sda, oe, bus_en, abort, permit, irq;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = '0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, abort_seen, pin_d;
   logic [1:0] bresp, rresp, rsp;
   int fail_count = 0, num_checks = 0, cyc = 0, n, t0;

   sswd_top #(.TICK_CYC(TK), .POR_MS(PM), .LOW_MS(LM), .RESET_ACTIVE_HIGH(1'h0)) i_dut (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .wp_in(wp),
      .supply_low_in(low), .nv_write_busy(nvb), .sys_reset_o(pin_d), .sys_reset_oe(oe),
      .bus_enable(bus_en), .comm_abort(abort), .nv_write_permit(permit), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   sswd_host_model i_host (.go(go), .hold_low(hold), .scl(scl), .sda(sda));

   always #10 clk = ~clk;

   // cycle count doubles as the hang limit; the full run needs about 40000
   always @(posedge clk) begin
      cyc++;
      if (abort === 1'h1) abort_seen <= 1'h1;
      if (cyc == 70000) begin
         fail_count++;
         finish_test();
      end
   end

   function automatic int wd_ms(input int c);
      return (c == 0) ? 1400 : (c == 1) ? 600 : 200;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi);
      check(32'(v >= lo && v <= hi), 32'h1);
   endtask

   // handshakes are judged at the falling edge, where ready has settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      ta = 1'h0;
      tw = 1'h0;
      // let the valid levels settle before the loop tests them
      #1;
      while (awvalid || wvalid) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         #1;
      end
      while (bvalid !== 1'h1) @(negedge clk);
      rsp = bresp;
      @(posedge clk);
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      @(negedge clk);
      while (arready !== 1'h1) @(negedge clk);
      @(posedge clk);
      arvalid <= 1'h0;
      @(negedge clk);
      while (rvalid !== 1'h1) @(negedge clk);
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      rready <= 1'h0;
   endtask

   task automatic wait_oe(input logic lvl, input int max);
      n = 0;
      while (oe !== lvl && n < max) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic start_pulse();
      @(posedge clk);
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(18));
      abort_seen = 1'h0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      t0 = cyc;
      // power-up hold with the bus shut and factory settings in place
      @(negedge clk);
      check(32'(bus_en), 32'h0);
      check(32'(pin_d), 32'h0);
      check(32'(oe), 32'h1);
      axi_rd(CTRL_OFS);
      check(32'(rd[7:5]), 32'h3);
      axi_rd(STATUS_OFS);
      check(32'(rd[ST_POR_POS]), 32'h1);
      wait_oe(1'h0, 200);
      in_range(cyc - t0, (PM - 1) * TK, (PM + 1) * TK + 10);
      axi_rd(8'h40);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_wr(8'h44, $urandom);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_wr(IRQ_MASK_OFS, 32'h7);
      // random start spacing below the 200 ms interval never resets
      axi_wr(CTRL_OFS, ($urandom & 32'hffffff00) | 32'h40);
      repeat (6) begin
         start_pulse();
         wait_oe(1'h1, $urandom_range(100, 180) * TK);
         check(32'(oe), 32'h0);
      end
      // each timed period code (00, 01, 10) times out after its own interval
      for (int c = 0; c < 3; c++) begin
         axi_wr(CTRL_OFS, 32'(c) << 5);
         start_pulse();
         abort_seen <= 1'h0;
         wait_oe(1'h1, 20000);
         in_range(n, (wd_ms(c) - 1) * TK, wd_ms(c) * TK + 20);
         repeat (3) @(negedge clk);
         check(32'(abort_seen), 32'h1);
         check(32'(bus_en), 32'h0);
         wait_oe(1'h0, 200);
      end
      // masked timeout stays quiet until unmasked, then clears by write-one
      axi_wr(IRQ_STAT_OFS, 32'h7);
      axi_wr(IRQ_MASK_OFS, 32'h6);
      wait_oe(1'h1, 3000);
      in_range(n, (WD_SHORT_MS - 1) * TK - 20, WD_SHORT_MS * TK + 20);
      axi_rd(IRQ_STAT_OFS);
      check(32'(rd[EV_WD]), 32'h1);
      check(32'(irq), 32'h0);
      axi_wr(IRQ_MASK_OFS, 32'h7);
      repeat (3) @(negedge clk);
      check(32'(irq), 32'h1);
      axi_wr(IRQ_STAT_OFS, 32'h7);
      repeat (3) @(negedge clk);
      check(32'(irq), 32'h0);
      wait_oe(1'h0, 200);
      // disabled watchdog ignores a data line stuck low
      axi_wr(CTRL_OFS, 32'h60);
      hold <= 1'h1;
      wait_oe(1'h1, 3000);
      check(32'(n), 32'd3000);
      @(posedge clk);
      hold <= 1'h0;
      // protect pin plus enable bit freeze the control bits
      axi_wr(CTRL_OFS, 32'he0);
      wp <= 1'h1;
      repeat (6) @(posedge clk);
      axi_wr(CTRL_OFS, 32'h40);
      check(32'(rsp), 32'(RESP_OKAY));
      axi_rd(CTRL_OFS);
      check(32'(rd[7:5]), 32'h7);
      axi_rd(IRQ_STAT_OFS);
      check(32'(rd[EV_BLOCK]), 32'h1);
      wp <= 1'h0;
      repeat (6) @(posedge clk);
      axi_wr(CTRL_OFS, 32'h20);
      axi_rd(CTRL_OFS);
      check(32'(rd[7:5]), 32'h1);
      // supply dip with a running nonvolatile write, then a relapse mid-delay
      @(posedge clk);
      low <= 1'h1;
      nvb <= 1'h1;
      wait_oe(1'h1, 20);
      in_range(n, 1, 8);
      check(32'(permit), 32'h1);
      @(posedge clk);
      nvb <= 1'h0;
      repeat (2) @(negedge clk);
      check(32'(permit), 32'h0);
      @(posedge clk);
      low <= 1'h0;
      repeat ((LM - 2) * TK) @(posedge clk);
      low <= 1'h1;
      repeat (5) @(posedge clk);
      low <= 1'h0;
      t0 = cyc;
      wait_oe(1'h0, 200);
      in_range(cyc - t0, (LM - 1) * TK, (LM + 1) * TK + 10);
      axi_rd(CTRL_OFS);
      check(32'(rd[7:5]), 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
